/* dpra_map.svh */
`ifndef DPRA_MAP_SVH
`define DPRA_MAP_SVH
// Pin widths
`define DPRA_ADDR_W        16
`define DPRA_DATA_W        18
`define DPRA_TOKEN_W       3
// Mailbox words, 64K organization
`define DPRA_MBOX_RIGHT    16'hFFFF
`define DPRA_MBOX_LEFT     16'hFFFE
// Data bit carrying the token value
`define DPRA_TOKEN_BIT     0
// Timing, ns, with derived cycle counts at 20 MHz
`define DPRA_CLK_NS        50
`define DPRA_SETUP_NS      100
`define DPRA_STROBE_NS     150
`define DPRA_FLOW_NS       100
`define DPRA_SOP_NS        100
`define DPRA_BUSY_NS       100
`define DPRA_CYC(ns)       (((ns) + `DPRA_CLK_NS - 1) / `DPRA_CLK_NS)
`define DPRA_SETUP_CYC     `DPRA_CYC(`DPRA_SETUP_NS)
`define DPRA_STROBE_CYC    `DPRA_CYC(`DPRA_STROBE_NS)
`define DPRA_FLOW_CYC      `DPRA_CYC(`DPRA_FLOW_NS)
`define DPRA_SOP_CYC       `DPRA_CYC(`DPRA_SOP_NS)
`define DPRA_BUSY_CYC      `DPRA_CYC(`DPRA_BUSY_NS)
`endif

/* dpra_pkg.sv */
package dpra_pkg;
    typedef enum logic [1:0] {
        DPRA_OP_MEM_RD,
        DPRA_OP_MEM_WR,
        DPRA_OP_TOKEN_GET,
        DPRA_OP_TOKEN_PUT
    } dpra_op_t;
    typedef enum {
        DPRA_IDLE,
        DPRA_SETUP,
        DPRA_STROBE,
        DPRA_RECOVER,
        DPRA_DONE
    } dpra_state_t;
endpackage : dpra_pkg

/* dpra_tick_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface dpra_tick_if;
    logic       load;
    logic [3:0] count;
    logic       expired;
    modport timer (input load, input count, output expired);
    modport user  (output load, output count, input expired);
endinterface : dpra_tick_if
`default_nettype wire

/* dpra_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module dpra_timer (
    input  wire logic   clk,     // System clock
    input  wire logic   sys_rst, // Synchronous reset
    dpra_tick_if.timer  tick     // Load and expiry
);
    logic [3:0] left_reg;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            left_reg <= 4'h0;
        end else if (tick.load) begin
            left_reg <= tick.count;
        end else if (left_reg != 4'h0) begin
            left_reg <= left_reg - 4'h1;
        end
    end

    // Expiry must not look at load, or the loader's decode loops back on itself
    assign tick.expired = (left_reg == 4'h0);
endmodule : dpra_timer
`default_nettype wire

/* dpra_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpra_map.svh"
// Overview of operation
// - Write ends by raising the strobe before chip select.
// - Read data sampled only after flowthrough delay past output enable.
// - Reads assert output enable with chip select or token select.
// - Write strobe waits until busy has settled and is inactive.
// - Token request writes zero, reads back; zero means owned.
// - Token select idles a minimum interval between write and readback.
// - Token access: token select low, chip select high, index on low bits.
module dpra_host
    import dpra_pkg::*;
(
    input  wire logic                     clk,          // 20 MHz clock
    input  wire logic                     sys_rst,      // Sync reset, high
    input  wire logic                     req_valid,    // Request strobe
    input  wire dpra_op_t                 req_op,       // Operation
    input  wire logic [`DPRA_ADDR_W-1:0]  req_addr,     // Word address
    input  wire logic [`DPRA_DATA_W-1:0]  req_wdata,    // Write data
    input  wire logic                     is_left,      // Host sits on left port
    output logic                          req_ready,    // Idle, may take request
    output logic                          rsp_valid,    // Done pulse
    output logic [`DPRA_DATA_W-1:0]       rsp_rdata,    // Read data
    output logic                          rsp_owned,    // Token obtained
    output logic                          rsp_busy,     // Busy seen in access
    output logic                          mbox_irq,     // Own mailbox flag
    output logic [`DPRA_ADDR_W-1:0]       mem_addr,     // Address pins
    output logic [`DPRA_DATA_W-1:0]       mem_dq_out,   // Data out
    output logic                          mem_dq_oe,    // Data output enable
    input  wire logic [`DPRA_DATA_W-1:0]  mem_dq_in,    // Data in
    output logic                          mem_cs_n,     // Chip select
    output logic                          mem_we_n,     // Read/write strobe
    output logic                          mem_oe_n,     // Output enable
    output logic                          token_latch_select_n, // Token select
    input  wire logic                     mem_busy_n,   // Busy from device
    input  wire logic                     mem_int_n     // Interrupt flag
);
    dpra_state_t state_reg;
    dpra_op_t    op_reg;
    logic        sop_wait_reg;
    logic        busy_seen_reg;
    logic        int_meta_reg;
    dpra_tick_if tick ();

    dpra_timer u_timer (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tick    (tick.timer)
    );

    wire is_token = (op_reg == DPRA_OP_TOKEN_GET) || (op_reg == DPRA_OP_TOKEN_PUT);
    wire is_write = (op_reg == DPRA_OP_MEM_WR) || (op_reg == DPRA_OP_TOKEN_PUT);
    wire take     = req_valid && req_ready;

    ////////////////////////////////////////////////////////////////////////////
    // Timer loads
    always_comb begin
        tick.load  = 1'b0;
        tick.count = 4'h0;
        if (state_reg == DPRA_IDLE && take) begin
            tick.load  = 1'b1;
            tick.count = 4'(`DPRA_BUSY_CYC);
        end else if (state_reg == DPRA_SETUP && tick.expired && mem_busy_n) begin
            tick.load  = 1'b1;
            tick.count = 4'(`DPRA_STROBE_CYC + `DPRA_FLOW_CYC);
        end else if (state_reg == DPRA_STROBE && tick.expired) begin
            tick.load  = 1'b1;
            tick.count = 4'(`DPRA_SOP_CYC);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= DPRA_IDLE;
            op_reg    <= DPRA_OP_MEM_RD;
        end else begin
            unique case (state_reg)
                DPRA_IDLE: begin
                    if (take) begin
                        op_reg    <= req_op;
                        state_reg <= DPRA_SETUP;
                    end
                end
                DPRA_SETUP: begin
                    if (tick.expired && mem_busy_n) begin
                        state_reg <= DPRA_STROBE;
                    end
                end
                DPRA_STROBE: begin
                    if (tick.expired) begin
                        state_reg <= DPRA_RECOVER;
                    end
                end
                DPRA_RECOVER: begin
                    state_reg <= DPRA_DONE;
                end
                DPRA_DONE: begin
                    state_reg <= DPRA_IDLE;
                end
            endcase
        end
    end

    // Token write followed by readback needs a quiet gap
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sop_wait_reg <= 1'b0;
        end else if (state_reg == DPRA_RECOVER && op_reg == DPRA_OP_TOKEN_PUT) begin
            sop_wait_reg <= 1'b1;
        end else if (state_reg == DPRA_IDLE && tick.expired) begin
            sop_wait_reg <= 1'b0;
        end
    end

    // Ready trails idle by a cycle, so it never overlaps a taken request
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            req_ready <= 1'b0;
        end else begin
            req_ready <= (state_reg == DPRA_IDLE) && !sop_wait_reg && !take;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mem_addr             <= '0;
            mem_dq_out           <= '0;
            mem_dq_oe            <= 1'b0;
            mem_cs_n             <= 1'b1;
            mem_we_n             <= 1'b1;
            mem_oe_n             <= 1'b1;
            token_latch_select_n <= 1'b1;
        end else begin
            unique case (state_reg)
                DPRA_IDLE: begin
                    mem_cs_n             <= 1'b1;
                    token_latch_select_n <= 1'b1;
                    mem_dq_oe            <= 1'b0;
                    if (take) begin
                        if (req_op == DPRA_OP_TOKEN_GET || req_op == DPRA_OP_TOKEN_PUT) begin
                            mem_addr <= {{(`DPRA_ADDR_W-`DPRA_TOKEN_W){1'b0}},
                                         req_addr[`DPRA_TOKEN_W-1:0]};
                            mem_dq_out <= {`DPRA_DATA_W{req_wdata[`DPRA_TOKEN_BIT]}};
                            token_latch_select_n <= 1'b0;
                        end else begin
                            mem_addr   <= req_addr;
                            mem_dq_out <= req_wdata;
                            mem_cs_n   <= 1'b0;
                        end
                        mem_dq_oe <= (req_op == DPRA_OP_MEM_WR) || (req_op == DPRA_OP_TOKEN_PUT);
                    end
                end
                DPRA_SETUP: begin
                    if (tick.expired && mem_busy_n) begin
                        mem_we_n <= !is_write;
                        mem_oe_n <= is_write;
                    end
                end
                DPRA_STROBE: begin
                    if (tick.expired) begin
                        mem_we_n <= 1'b1;
                        mem_oe_n <= 1'b1;
                    end
                end
                DPRA_RECOVER: begin
                    mem_cs_n             <= 1'b1;
                    token_latch_select_n <= 1'b1;
                end
                DPRA_DONE: begin
                    mem_dq_oe <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Answer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rsp_valid     <= 1'b0;
            rsp_rdata     <= '0;
            rsp_owned     <= 1'b0;
            rsp_busy      <= 1'b0;
            busy_seen_reg <= 1'b0;
        end else begin
            rsp_valid <= (state_reg == DPRA_DONE);
            if (state_reg == DPRA_IDLE) begin
                busy_seen_reg <= 1'b0;
            end else if (!mem_busy_n) begin
                busy_seen_reg <= 1'b1;
            end
            if (state_reg == DPRA_STROBE && tick.expired && !is_write) begin
                rsp_rdata <= mem_dq_in;
                rsp_owned <= is_token && !mem_dq_in[`DPRA_TOKEN_BIT];
            end
            if (state_reg == DPRA_DONE) begin
                rsp_busy <= busy_seen_reg;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            int_meta_reg <= 1'b0;
            mbox_irq     <= 1'b0;
        end else begin
            int_meta_reg <= !mem_int_n;
            mbox_irq     <= int_meta_reg;
        end
    end

    wire unused_side = is_left;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_strobe_low;
        !mem_we_n;
    endsequence
    property p_cs_idle;
        @(posedge clk) disable iff (sys_rst)
            (state_reg == DPRA_IDLE && $past(state_reg) == DPRA_IDLE) |-> mem_cs_n;
    endproperty
    a_cs_idle: assert property (p_cs_idle) else $error("cs active while idle");
    property p_we_first;
        @(posedge clk) disable iff (sys_rst)
            $rose(mem_we_n) |->
                (!mem_cs_n || !token_latch_select_n) ##1 (mem_cs_n && token_latch_select_n);
    endproperty
    a_we_first: assert property (p_we_first) else $error("write end order");
    property p_excl;
        @(posedge clk) disable iff (sys_rst) !(!mem_cs_n && !token_latch_select_n);
    endproperty
    a_excl: assert property (p_excl) else $error("cs and token select both low");
    property p_strobe_busy;
        @(posedge clk) disable iff (sys_rst) $fell(mem_we_n) |-> $past(mem_busy_n);
    endproperty
    a_strobe_busy: assert property (p_strobe_busy) else $error("write during busy");
    property p_read_oe;
        @(posedge clk) disable iff (sys_rst)
            !mem_oe_n |-> (!mem_cs_n || !token_latch_select_n) && mem_we_n;
    endproperty
    a_read_oe: assert property (p_read_oe) else $error("read without select");
    property p_no_both;
        @(posedge clk) disable iff (sys_rst) s_strobe_low |-> mem_oe_n && mem_dq_oe;
    endproperty
    a_no_both: assert property (p_no_both) else $error("strobe with oe");
    property p_sop;
        @(posedge clk) disable iff (sys_rst)
            ($rose(token_latch_select_n) && op_reg == DPRA_OP_TOKEN_PUT) |->
                token_latch_select_n [*2];
    endproperty
    a_sop: assert property (p_sop) else $error("token gap too short");
    property p_tok_addr;
        @(posedge clk) disable iff (sys_rst)
            !token_latch_select_n |-> mem_addr[`DPRA_ADDR_W-1:`DPRA_TOKEN_W] == '0;
    endproperty
    a_tok_addr: assert property (p_tok_addr) else $error("token address high bits");
endmodule : dpra_host
`default_nettype wire

/* dpra_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpra_map.svh"
module dpra_dev_model (
    input  wire logic        cs_n,     // Chip select
    input  wire logic        we_n,     // Write strobe
    input  wire logic        oe_n,     // Output enable
    input  wire logic        sel_n,    // Token select
    input  wire logic [15:0] addr,     // Address
    input  wire logic [17:0] din,      // Data from host
    input  wire logic        busy_req, // Far port contention
    output logic      [17:0] dout,     // Data to host
    output logic             busy_n,   // Busy to host
    output logic             int_n     // Host mailbox flag
);
    logic [17:0] mem [0:65535];
    logic [1:0]  owner [8]; // 0 free, 1 host, 2 far
    logic [7:0]  pend_far;
    logic [7:0]  pend_host;
    logic        far_int;
    logic        tok_q;
    logic [17:0] last;
    logic [17:0] rv;
    wire logic   wr  = ~cs_n & ~we_n;
    wire logic   twr = ~sel_n & ~we_n;
    wire logic   rd  = ~cs_n & ~oe_n & we_n;
    wire logic   trd = ~sel_n & ~oe_n & we_n;
    wire logic [2:0] ix = addr[2:0];
    initial begin
        int_n = 1; far_int = 0; pend_far = 0; pend_host = 0; tok_q = 1; last = 0;
        foreach (owner[k]) owner[k] = 0;
    end
    assign busy_n = ~busy_req;
    assign rv = mem[addr];
    // Undriven bus shows the inverse of the last value
    assign dout = rd ? rv : (trd ? {18{tok_q}} : ~last);
    always @(negedge rd) last = rv;
    always @(negedge trd) last = {18{tok_q}};
    always @(negedge wr) begin
        mem[addr] = din;
        if (addr == `DPRA_MBOX_RIGHT && busy_n) far_int = 1;
    end
    always @(posedge rd) if (addr == `DPRA_MBOX_LEFT && busy_n) int_n = 1;
    always @(posedge trd) tok_q = (owner[ix] != 1);
    always @(negedge twr) begin
        if (!din[0]) begin
            if (owner[ix] == 0) owner[ix] = 1;
            else if (owner[ix] == 2) pend_host[ix] = 1;
        end else if (owner[ix] == 1) begin
            owner[ix] = pend_far[ix] ? 2'd2 : 2'd0;
            pend_far[ix] = 0;
        end else pend_host[ix] = 0;
    end
    task automatic far_put(input int i, input logic b);
        if (!b) begin
            if (owner[i] == 0) owner[i] = 2;
            else if (owner[i] == 1) pend_far[i] = 1;
        end else if (owner[i] == 2) begin
            owner[i] = pend_host[i] ? 2'd1 : 2'd0;
            pend_host[i] = 0;
        end else pend_far[i] = 0;
    endtask : far_put
    function automatic logic far_view(input int i);
        return owner[i] != 2;
    endfunction : far_view
    task automatic far_mbox_write();
        int_n = 0;
    endtask : far_mbox_write
endmodule : dpra_dev_model
`default_nettype wire

/* dpra_host_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpra_map.svh"
module dpra_host_tb
    import dpra_pkg::*;
;
    logic clk, sys_rst, req_valid, req_ready, rsp_valid, rsp_owned, rsp_busy, mbox_irq;
    logic mem_dq_oe, mem_cs_n, mem_we_n, mem_oe_n, token_latch_select_n;
    logic mem_busy_n, mem_int_n, busy_req;
    dpra_op_t req_op;
    logic [15:0] req_addr, mem_addr;
    logic [17:0] req_wdata, rsp_rdata, mem_dq_out, mem_dq_in;
    int error_cnt = 0;
    int cmp_count = 0;
    dpra_host u_dpra_host (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
        .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .is_left(1'b1),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_owned(rsp_owned),
        .rsp_busy(rsp_busy), .mbox_irq(mbox_irq), .mem_addr(mem_addr),
        .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe), .mem_dq_in(mem_dq_in),
        .mem_cs_n(mem_cs_n), .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n),
        .token_latch_select_n(token_latch_select_n), .mem_busy_n(mem_busy_n),
        .mem_int_n(mem_int_n));
    dpra_dev_model u_dpra_dev_model (.cs_n(mem_cs_n), .we_n(mem_we_n), .oe_n(mem_oe_n),
        .sel_n(token_latch_select_n), .addr(mem_addr), .din(mem_dq_out),
        .busy_req(busy_req), .dout(mem_dq_in), .busy_n(mem_busy_n), .int_n(mem_int_n));
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    task automatic end_of_test();
        if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic op(input dpra_op_t o, input logic [15:0] a, input logic [17:0] d);
        int n;
        n = 0;
        @(posedge clk) #1;
        req_valid = 1; req_op = o; req_addr = a; req_wdata = d;
        @(posedge clk);
        while (req_ready !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        #1;
        req_valid = 0;
        while (rsp_valid !== 1'b1 && n < 300) begin
            @(posedge clk) #1;
            n++;
        end
        if (n == 300) begin
            error_cnt++;
            end_of_test();
        end else repeat (3) @(posedge clk);
    endtask : op
    always @(posedge clk) if (sys_rst === 1'b0) begin
        chk({17'h0, ~token_latch_select_n & ~mem_cs_n}, 18'h0_0000);
        chk({17'h0, ~mem_busy_n & ~mem_we_n}, 18'h0_0000);
    end
    initial begin
        logic [15:0] a;
        logic [17:0] d;
        sys_rst = 1; req_valid = 0; req_op = DPRA_OP_MEM_RD; req_addr = 0;
        req_wdata = 0; busy_req = 0;
        void'($urandom(43317));
        repeat (4) @(posedge clk);
        #1 sys_rst = 0;
        // Memory words, edges of the plain range first
        for (int i = 0; i < 8; i++) begin
            a = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFD : 16'($urandom % 32'hFFFE);
            d = 18'($urandom);
            op(DPRA_OP_MEM_WR, a, d);
            op(DPRA_OP_MEM_RD, a, 18'h0_0000);
            chk(rsp_rdata, d);
            chk({16'h0, mem_cs_n, token_latch_select_n}, 18'h0_0003);
        end
        // All eight tokens, high address bits random
        for (int i = 0; i < 8; i++) begin
            a = (16'($urandom) & 16'hFFF8) | 16'(i);
            op(DPRA_OP_TOKEN_PUT, a, 18'h3_FFFE);
            op(DPRA_OP_TOKEN_GET, a, 18'h0_0000);
            chk(rsp_rdata, 18'h0_0000);
            chk({17'h0, rsp_owned}, 18'h0_0001);
            chk({17'h0, u_dpra_dev_model.far_view(i)}, 18'h0_0001);
            u_dpra_dev_model.far_put(i, 1'b0);
            op(DPRA_OP_TOKEN_PUT, a, 18'h0_0001);
            op(DPRA_OP_TOKEN_GET, a, 18'h0_0000);
            chk(rsp_rdata, 18'h3_FFFF);
            chk({17'h0, rsp_owned}, 18'h0_0000);
            op(DPRA_OP_TOKEN_PUT, a, 18'h0_0000);
            u_dpra_dev_model.far_put(i, 1'b1);
            op(DPRA_OP_TOKEN_GET, a, 18'h0_0000);
            chk({17'h0, rsp_owned}, 18'h0_0001);
            op(DPRA_OP_TOKEN_PUT, a, 18'h0_0001);
            chk({17'h0, u_dpra_dev_model.far_view(i)}, 18'h0_0001);
        end
        // Mailbox flags
        u_dpra_dev_model.far_mbox_write();
        repeat (4) @(posedge clk);
        chk({17'h0, mbox_irq}, 18'h0_0001);
        op(DPRA_OP_MEM_RD, `DPRA_MBOX_RIGHT, 18'h0_0000);
        chk({17'h0, mbox_irq}, 18'h0_0001);
        op(DPRA_OP_MEM_RD, `DPRA_MBOX_LEFT, 18'h0_0000);
        chk({17'h0, mbox_irq}, 18'h0_0000);
        op(DPRA_OP_MEM_WR, `DPRA_MBOX_RIGHT, 18'h1_2345);
        chk({17'h0, u_dpra_dev_model.far_int}, 18'h0_0001);
        chk({17'h0, rsp_busy}, 18'h0_0000);
        // Write held off by contention
        fork
            op(DPRA_OP_MEM_WR, `DPRA_MBOX_RIGHT, 18'h0_5A5A);
            begin
                @(posedge clk) #1 busy_req = 1;
                repeat (6) @(posedge clk);
                #1 busy_req = 0;
            end
        join
        chk({17'h0, rsp_busy}, 18'h0_0001);
        end_of_test();
    end
endmodule : dpra_host_tb
`default_nettype wire
